// File: hw/actuator_teach_in_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "teach_in_regs.svh"
// reset models the power cycle; taught code and inhibit flag sit in
// state kept outside reset (reloaded from nv*) as nonvolatile storage would.
module actuator_teach_in_control #(
	parameter int unsigned TICK_DIV    = `CLK_HZ / `TICK_HZ,
	parameter int unsigned WAIT_TICKS  = `PAIR_WAIT_S * `TICK_HZ,
	parameter int unsigned REQ_TICKS   = `POWER_REQ_S * `TICK_HZ,
	parameter int unsigned INH_TICKS   = `INHIBIT_S * `TICK_HZ
) (
	// clock and reset (reset = power-on)
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// variant straps
	input  wire logic                 individualCoding,
	input  wire logic                 oneTimePairingVariant,
	// nonvolatile image restored at power-on
	input  wire logic [`CODE_W-1:0]   nvStoredCode,
	input  wire logic                 nvPaired,
	input  wire logic                 nvPending,
	input  wire logic                 nvInhibit,
	// actuator reader
	input  wire logic                 actPresent,
	input  wire logic [`CODE_W-1:0]   actCode,
	// nonvolatile image to store
	output logic [`CODE_W-1:0]        storeCode,
	output logic                      storePaired,
	output logic                      storePending,
	output logic                      storeInhibit,
	// indicators and enable
	output logic                      ledGreen,
	output logic                      ledRed,
	output logic                      ledYellow,
	output logic                      enableOk
);
	logic tick;
	tick_divider #(.DIV(TICK_DIV)) u_div (
		.sys_clk(sys_clk),
		.reset  (reset),
		.tick   (tick)
	);

	// pins from outside the clock domain
	logic               presSync1_ff, presSync2_ff;
	logic [`CODE_W-1:0] codeSync1_ff, codeSync2_ff;
	always_ff @(posedge sys_clk) begin
		presSync1_ff <= actPresent;
		presSync2_ff <= presSync1_ff;
		codeSync1_ff <= actCode;
		codeSync2_ff <= codeSync1_ff;
	end

	teach_in_pkg::phase_e phase_ff, nxt_phase;
	logic [31:0]        timer_ff, nxt_timer;
	logic [2:0]         phaseCnt_ff, nxt_phaseCnt;
	logic [3:0]         blinks_ff, nxt_blinks;
	logic [`CODE_W-1:0] code_ff, nxt_code, cand_ff, nxt_cand;
	logic               paired_ff, nxt_paired;
	logic               pending_ff, nxt_pending;
	logic               inhibit_ff, nxt_inhibit;
	logic               loaded_ff;
	logic               fresh_ff, nxt_fresh;
	logic               gOut, rOut, yOut, enOut;
	logic               known;

	// nv image is caught in the first cycle after reset releases; straps are read live
	always_ff @(posedge sys_clk) begin
		if (reset)
			loaded_ff <= 1'b0;
		else
			loaded_ff <= 1'b1;
	end

	always_comb begin
		nxt_phase = phase_ff;
		nxt_timer = timer_ff;
		nxt_phaseCnt = phaseCnt_ff;
		nxt_blinks = blinks_ff;
		nxt_code = code_ff;
		nxt_cand = cand_ff;
		nxt_paired = paired_ff;
		nxt_pending = pending_ff;
		nxt_inhibit = inhibit_ff;
		nxt_fresh = fresh_ff;
		known = !individualCoding || (paired_ff && codeSync2_ff == code_ff);
		if (tick) begin
			nxt_timer = timer_ff + 32'h1;
			nxt_phaseCnt = phaseCnt_ff + 3'h1;
			if (phaseCnt_ff == 3'(`TICK_HZ - 1))
				nxt_phaseCnt = 3'h0;
		end
		if (!loaded_ff) begin
			nxt_code = nvStoredCode;
			nxt_cand = nvStoredCode;
			nxt_paired = nvPaired;
			nxt_pending = nvPending;
			nxt_inhibit = nvInhibit;
			nxt_fresh = 1'b1;
			nxt_timer = 32'h0;
			nxt_phase = nvPending ? teach_in_pkg::ST_CONFIRM
				: nvInhibit ? teach_in_pkg::ST_INHIBIT
				: teach_in_pkg::ST_IDLE;
		end else begin
			unique case (phase_ff)
			teach_in_pkg::ST_IDLE: begin
				if (presSync2_ff && !known && individualCoding) begin
					if (paired_ff && oneTimePairingVariant) begin
						nxt_phase = teach_in_pkg::ST_FAULT;
						nxt_blinks = 4'h0;
					end else if (!fresh_ff) begin
						// teach-in needs a power cycle first
						nxt_phase = teach_in_pkg::ST_FAULT;
						nxt_blinks = 4'h0;
					end else begin
						nxt_phase = teach_in_pkg::ST_PAIR;
						nxt_cand = codeSync2_ff;
						nxt_timer = 32'h0;
					end
				end else if (presSync2_ff && known)
					nxt_phase = teach_in_pkg::ST_RUN;
			end
			teach_in_pkg::ST_PAIR: begin
				if (timer_ff >= WAIT_TICKS) begin
					nxt_phase = teach_in_pkg::ST_PWRREQ;
					nxt_pending = 1'b1;
					nxt_timer = 32'h0;
				end
			end
			teach_in_pkg::ST_PWRREQ: begin
				if (timer_ff >= REQ_TICKS) begin
					nxt_phase = teach_in_pkg::ST_FAULT;
					nxt_pending = 1'b0;
					nxt_blinks = 4'h0;
				end
			end
			teach_in_pkg::ST_FAULT: begin
				// five blinks, then back to waiting
				if (tick && phaseCnt_ff == 3'(`TICK_HZ - 1)) begin
					nxt_blinks = blinks_ff + 4'h1;
					if (blinks_ff == 4'(`FAULT_BLINKS - 1))
						nxt_phase = teach_in_pkg::ST_IDLE;
				end
			end
			teach_in_pkg::ST_CONFIRM: begin
				if (presSync2_ff && codeSync2_ff == cand_ff) begin
					nxt_code = cand_ff;
					nxt_paired = 1'b1;
					nxt_pending = 1'b0;
					nxt_inhibit = 1'b1;
					nxt_timer = 32'h0;
					nxt_phase = teach_in_pkg::ST_INHIBIT;
				end
			end
			teach_in_pkg::ST_INHIBIT: begin
				if (timer_ff >= INH_TICKS)
					nxt_inhibit = 1'b0;
				if (!inhibit_ff && presSync2_ff && known)
					nxt_phase = teach_in_pkg::ST_RUN;
			end
			teach_in_pkg::ST_RUN: begin
				if (!presSync2_ff)
					nxt_phase = teach_in_pkg::ST_IDLE;
				else if (!known) begin
					nxt_phase = teach_in_pkg::ST_FAULT;
					nxt_blinks = 4'h0;
				end
			end
			default: nxt_phase = teach_in_pkg::ST_IDLE;
			endcase
			if (presSync2_ff)
				nxt_fresh = 1'b0;
		end
		// patterns restart on entry, so no phase opens with a stub flash
		if (nxt_phase != phase_ff)
			nxt_phaseCnt = 3'h0;
	end

	// 6 Hz ticks: 1 Hz = 3 on / 3 off, 3 Hz = toggle each tick
	always_comb begin
		gOut = 1'b1;
		rOut = 1'b0;
		yOut = 1'b0;
		enOut = 1'b0;
		unique case (phase_ff)
		teach_in_pkg::ST_PAIR: begin
			gOut = 1'b0;
			rOut = 1'b1;
			yOut = phaseCnt_ff < 3'(`TICK_HZ / 2);
		end
		teach_in_pkg::ST_PWRREQ: begin
			gOut = 1'b0;
			rOut = 1'b1;
			// starts lit, continuing the last lit tick of pairing
			yOut = !phaseCnt_ff[0];
		end
		// dark half first, so the first flash stands out after steady red
		teach_in_pkg::ST_FAULT:
			rOut = phaseCnt_ff >= 3'(`TICK_HZ / 2);
		teach_in_pkg::ST_INHIBIT:
			gOut = phaseCnt_ff < 3'(`TICK_HZ / 2);
		teach_in_pkg::ST_RUN: begin
			yOut = 1'b1;
			enOut = 1'b1;
		end
		default: ;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phase_ff <= teach_in_pkg::ST_IDLE;
			timer_ff <= 32'h0;
			phaseCnt_ff <= 3'h0;
			blinks_ff <= 4'h0;
			fresh_ff <= 1'b0;
			ledGreen <= 1'b0;
			ledRed <= 1'b0;
			ledYellow <= 1'b0;
			enableOk <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			timer_ff <= nxt_timer;
			phaseCnt_ff <= nxt_phaseCnt;
			blinks_ff <= nxt_blinks;
			fresh_ff <= nxt_fresh;
			ledGreen <= gOut;
			ledRed <= rOut;
			ledYellow <= yOut;
			enableOk <= enOut;
		end
	end

	// nonvolatile shadow: not cleared by reset, reloaded after it
	always_ff @(posedge sys_clk) begin
		code_ff <= nxt_code;
		cand_ff <= nxt_cand;
		paired_ff <= nxt_paired;
		pending_ff <= nxt_pending;
		inhibit_ff <= nxt_inhibit;
		storeCode <= nxt_pending ? nxt_cand : nxt_code;
		storePaired <= nxt_paired;
		storePending <= nxt_pending;
		storeInhibit <= nxt_inhibit;
	end
endmodule
`default_nettype wire

// File: hw/teach_in_regs.svh
// Notes on behaviour
// - standard-coded unit works without pairing
// - coded unit pairs new actuator after power-up
// - pairing: green off, red on, yellow 1 Hz
// - after 10 s yellow 3 Hz requests power-off
// - no power-off in 5 min: abort, 5 red blinks
// - new code active only after redetection
// - one-time variant refuses further pairing
// - repeatable variant pairs any number of times
// - new pairing invalidates old stored code
// - enabling blocked ten minutes after pairing
// - green blinks until inhibit over and detected
// - power fail during inhibit restarts ten minutes
// - five red blinks: bad actuator, outputs off
`ifndef TEACH_IN_REGS_SVH
`define TEACH_IN_REGS_SVH
`define CLK_HZ         40000000
`define TICK_HZ        6
`define PAIR_WAIT_S    10
`define POWER_REQ_S    300
`define INHIBIT_S      600
`define FAULT_BLINKS   5
`define CODE_W         32
`endif

// File: hw/teach_in_pkg.sv
package teach_in_pkg;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PAIR    = 3'b001,
		ST_PWRREQ  = 3'b010,
		ST_FAULT   = 3'b011,
		ST_CONFIRM = 3'b100,
		ST_INHIBIT = 3'b101,
		ST_RUN     = 3'b110
	} phase_e;
endpackage

// File: hw/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "teach_in_regs.svh"
module tick_divider #(
	parameter int unsigned DIV = `CLK_HZ / `TICK_HZ
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// enable pulse
	output logic      tick
);
	logic [31:0] count_ff;
	logic [31:0] nxt_count;
	logic        nxt_tick;

	always_comb begin
		nxt_count = count_ff + 32'h1;
		nxt_tick = 1'b0;
		if (count_ff == DIV - 1) begin
			nxt_count = 32'h0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_ff <= 32'h0;
			tick <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			tick <= nxt_tick;
		end
	end
endmodule
`default_nettype wire

// File: testbench/teach_in_properties.sv
`timescale 1ns/100ps
`default_nettype none
module teach_in_properties (
	// clock and power-on
	input wire logic sys_clk,
	input wire logic reset,
	// strap and reader
	input wire logic individualCoding,
	input wire logic actPresent,
	// indicators and enable
	input wire logic ledGreen,
	input wire logic ledRed,
	input wire logic ledYellow,
	input wire logic enableOk
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_power_dark: assert property (
		$past(reset) |-> !(enableOk | ledRed | ledYellow | ledGreen))
		else $error("outputs lit at power-on");
	chk_std_runs: assert property (
		(!individualCoding && actPresent) [*7] |-> enableOk)
		else $error("standard unit not enabled");
	chk_red_blocks: assert property (ledRed |-> !enableOk)
		else $error("enable while red lit");
	chk_pair_green: assert property (
		ledRed && ledYellow |-> !ledGreen) else $error("green lit in pairing");
	chk_yel_high: assert property (
		$rose(ledYellow) && ledRed |-> ledYellow [*4])
		else $error("yellow high shorter than a tick");
	chk_yel_low: assert property (
		$fell(ledYellow) && ledRed |=> !ledYellow [*3])
		else $error("yellow low shorter than a tick");
	chk_absent_off: assert property (
		!actPresent [*6] |-> !enableOk) else $error("enable without actuator");
	chk_run_yellow: assert property (
		$rose(enableOk) |-> ledYellow) else $error("enable without yellow");
	cover property (ledRed && ledYellow);
	cover property ($rose(ledGreen));
	cover property ($rose(enableOk) && individualCoding);
endmodule
bind actuator_teach_in_control teach_in_properties chk (.sys_clk(sys_clk),
	.reset(reset), .individualCoding(individualCoding),
	.actPresent(actPresent), .ledGreen(ledGreen), .ledRed(ledRed),
	.ledYellow(ledYellow), .enableOk(enableOk));
`default_nettype wire

// File: testbench/actuator_partner.sv
`timescale 1ns/100ps
`default_nettype none
`include "teach_in_regs.svh"
module actuator_partner (
	// clock and power-on
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// actuator in range and its code
	input  wire logic                insert,
	input  wire logic [`CODE_W-1:0]  tagCode,
	output logic                     actPresent,
	output logic [`CODE_W-1:0]       actCode,
	// nonvolatile image
	input  wire logic [`CODE_W-1:0]  storeCode,
	input  wire logic                storePaired,
	input  wire logic                storePending,
	input  wire logic                storeInhibit,
	output logic [`CODE_W-1:0]       nvStoredCode,
	output logic                     nvPaired,
	output logic                     nvPending,
	output logic                     nvInhibit
);
	logic live;
	logic primed = 1'b0;
	assign actPresent = insert;
	// absent reader data is scrambled, never the last code
	assign actCode = insert ? tagCode : ~tagCode;
	// store outputs are undefined until one cycle after power-on;
	// the image is blank before the very first power-on
	always @(posedge sys_clk) begin
		live <= !reset;
		primed <= 1'b1;
		if (!primed)
			{nvStoredCode, nvPaired, nvPending, nvInhibit} <= '0;
		else if (live && !reset) begin
			{nvStoredCode, nvPaired} <= {storeCode, storePaired};
			{nvPending, nvInhibit} <= {storePending, storeInhibit};
		end
	end
endmodule
`default_nettype wire

// File: testbench/actuator_teach_in_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "teach_in_regs.svh"
module actuator_teach_in_control_tb;
	localparam int TD = 4;
	localparam int INH = 12;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic indiv = 1'h0;
	logic oneTime = 1'h0;
	logic insert = 1'h0;
	logic [`CODE_W-1:0] tag = 32'h0;
	wire logic [`CODE_W-1:0] nvCode, stCode, actCode;
	wire logic nvPaired, nvPending, nvInhibit, stPaired, stPending, stInhibit;
	wire logic actPresent, ledGreen, ledRed, ledYellow, enableOk;
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	always #12.5 sys_clk = ~sys_clk;
	actuator_teach_in_control #(.TICK_DIV(TD), .WAIT_TICKS(6),
		.REQ_TICKS(12), .INH_TICKS(INH)) uut (.sys_clk(sys_clk),
		.reset(reset), .individualCoding(indiv),
		.oneTimePairingVariant(oneTime), .nvStoredCode(nvCode),
		.nvPaired(nvPaired), .nvPending(nvPending), .nvInhibit(nvInhibit),
		.actPresent(actPresent), .actCode(actCode), .storeCode(stCode),
		.storePaired(stPaired), .storePending(stPending),
		.storeInhibit(stInhibit), .ledGreen(ledGreen), .ledRed(ledRed),
		.ledYellow(ledYellow), .enableOk(enableOk));
	actuator_partner mate (.sys_clk(sys_clk), .reset(reset),
		.insert(insert), .tagCode(tag), .actPresent(actPresent),
		.actCode(actCode), .storeCode(stCode), .storePaired(stPaired),
		.storePending(stPending), .storeInhibit(stInhibit),
		.nvStoredCode(nvCode), .nvPaired(nvPaired),
		.nvPending(nvPending), .nvInhibit(nvInhibit));
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pwr;
		reset = 1'h1;
		cyc(2);
		reset = 1'h0;
	endtask
	task automatic waitEn;
		for (n = 0; enableOk !== 1'h1 && n < 400; n++) cyc(1);
	endtask
	task automatic present(input logic [31:0] c);
		insert = 1'h0;
		pwr();
		cyc(4);
		tag = c;
		insert = 1'h1;
	endtask
	task automatic finish_test;
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_standard;
		tag = 32'hC0DE0001;
		insert = 1'h1;
		waitEn();
		chk("enableOk", 1, enableOk);
		chk("ledYellow", 1, ledYellow);
		insert = 1'h0;
		cyc(8);
		chk("enableOk", 0, enableOk);
		$display("standard coding test done");
	endtask
	task automatic t_pair(input logic [31:0] c);
		present(c);
		cyc(20);
		chk("ledGreen", 0, ledGreen);
		chk("ledRed", 1, ledRed);
		cyc(30);
		chk("storePending", 1, stPending);
		pwr();
		cyc(12);
		chk("enableOk", 0, enableOk);
		chk("storeInhibit", 1, stInhibit);
		// power fails mid-inhibit, so the full period must run again
		pwr();
		waitEn();
		chk("inhibitFull", 1, n >= INH * TD);
		chk("enableOk", 1, enableOk);
		chk("storeCode", c, stCode);
		chk("storePaired", 1, stPaired);
		$display("pairing test done");
	endtask
	task automatic t_old;
		insert = 1'h0;
		cyc(8);
		tag = 32'hA1A10001;
		insert = 1'h1;
		cyc(10);
		chk("enableOk", 0, enableOk);
		$display("old code test done");
	endtask
	task automatic t_abort;
		logic p;
		present(32'h3C3C0003);
		cyc(70);
		n = 0;
		p = ledRed;
		// window spans the fault phase only, not the next refusal
		repeat (120) begin
			cyc(1);
			n += (ledRed && !p);
			p = ledRed;
		end
		chk("redBlinks", 5, n);
		chk("storePending", 0, stPending);
		present(32'hB2B20002);
		waitEn();
		chk("enableOk", 1, enableOk);
		$display("abort test done");
	endtask
	task automatic t_once;
		oneTime = 1'h1;
		present(32'h3C3C0003);
		cyc(40);
		chk("storeCode", 32'hB2B20002, stCode);
		chk("enableOk", 0, enableOk);
		$display("one-time variant test done");
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		cyc(2);
		reset = 1'h0;
		t_standard();
		indiv = 1'h1;
		t_pair(32'hA1A10001);
		t_pair(32'hB2B20002);
		t_old();
		t_abort();
		t_once();
		finish_test();
	end
endmodule
`default_nettype wire
